/* File: hdl/idx_add_alu.sv */
// adder with full status flag generation for the indexed add
`timescale 1ns/1ps
`default_nettype none
module idx_add_alu
	import idx_ops_pkg::*;
(
	input wire logic [DATA_W-1:0] a,
	input wire logic [DATA_W-1:0] b,
	output logic [DATA_W-1:0] sum,
	output logic [4:0] flags
);
	logic [DATA_W:0] full;
	logic [NIB_W:0] low;
	always_comb
	begin
		full = {1'b0, a} + {1'b0, b};
		low = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]};
		sum = full[DATA_W-1:0];
		flags = FLAGS_RESET;
		flags[FLG_C] = full[DATA_W];
		flags[FLG_DC] = low[NIB_W];
		flags[FLG_Z] = (full[DATA_W-1:0] == BYTE_ZERO);
		// overflow: equal operand signs, different result sign
		flags[FLG_OV] = (a[DATA_W-1] == b[DATA_W-1]) && (full[DATA_W-1] != a[DATA_W-1]);
		flags[FLG_N] = full[DATA_W-1];
	end
endmodule // idx_add_alu
`default_nettype wire

/* File: hdl/idx_ops_pkg.sv */
// package: constants for the relative call, software reset and indexed literal offset unit
`default_nettype none
package idx_ops_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 21;
	localparam int ADDR_W = 12;
	localparam int OFS_W = 11;
	localparam int LIT_W = 7;
	localparam logic [LIT_W-1:0] LIT_MAX = 7'h5f;
	localparam logic signed [OFS_W-1:0] OFS_MIN = 11'sh400;
	localparam logic signed [OFS_W-1:0] OFS_MAX = 11'sh3ff;
	localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
	localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
	localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	// status flag positions
	localparam int FLG_C = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N = 4;
	localparam int NIB_W = 4;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_RELATIVE_CALL,
		OP_SOFT_RESET,
		OP_INDEXED_ADD_ACCUMULATOR,
		OP_INDEXED_BIT_SET,
		OP_INDEXED_FILL_ONES
	} op_e;
endpackage
`default_nettype wire

/* File: hdl/idx_ops_unit.sv */
// execution unit: relative call, software reset and indexed literal offset operations
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - the relative call takes a signed 11-bit word offset from -1024 to +1023.
// - the relative call pushes the following address, pc plus 2, to the return stack.
// - the relative call loads pc with pc plus 2 plus twice the signed offset.
// - the relative call takes two cycles, the second an idle refill cycle.
// - the software reset starts a reset equal to a master clear reset.
// - the indexed add sums accumulator and the byte at pointer plus offset 0 to 95.
// - destination select 0 writes the sum to the accumulator, 1 writes memory.
// - indexed bit set sets bit 0 to 7 of the indexed byte, others unchanged.
module idx_ops_unit
	import idx_ops_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire op_e op,
	input wire logic [PC_W-1:0] pc_in,
	input wire logic signed [OFS_W-1:0] call_offset,
	input wire logic [LIT_W-1:0] literal,
	input wire logic dest_sel,
	input wire logic [2:0] bit_sel,
	input wire logic [ADDR_W-1:0] second_indirect_pointer,
	input wire logic [DATA_W-1:0] mem_rdata,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_we,
	output logic [DATA_W-1:0] mem_wdata,
	output logic push_en,
	output logic [PC_W-1:0] top_of_return_stack,
	output logic pc_load,
	output logic [PC_W-1:0] pc_target,
	output logic busy,
	output logic soft_reset_req,
	output logic [DATA_W-1:0] acc,
	output logic [4:0] status_flags
);
	// ----------------------------------------
	// decode and operand forming
	// ----------------------------------------
	logic take;
	logic is_call;
	logic is_rst;
	logic is_add;
	logic is_bset;
	logic is_fill;
	logic lit_ok;
	logic [DATA_W-1:0] sum;
	logic [4:0] add_flags;
	logic [DATA_W-1:0] bit_mask;
	logic [PC_W-1:0] ret_addr;
	logic [PC_W-1:0] ofs_words;

	// second cycle of a call is idle: new requests are ignored then
	assign take = op_valid && !busy;
	assign is_call = take && (op == OP_RELATIVE_CALL);
	assign is_rst = take && (op == OP_SOFT_RESET);
	assign lit_ok = (literal <= LIT_MAX);
	// out of range literals are not executed
	assign is_add = take && (op == OP_INDEXED_ADD_ACCUMULATOR) && lit_ok;
	assign is_bset = take && (op == OP_INDEXED_BIT_SET) && lit_ok;
	assign is_fill = take && (op == OP_INDEXED_FILL_ONES) && lit_ok;

	assign mem_addr = second_indirect_pointer + ADDR_W'(literal);

	idx_add_alu u_alu (
		.a(acc),
		.b(mem_rdata),
		.sum(sum),
		.flags(add_flags)
	);

	assign bit_mask = DATA_W'(1) << bit_sel;
	assign ret_addr = pc_in + PC_STEP;
	// sign extension keeps the full 11-bit reach either way
	assign ofs_words = PC_W'(signed'(call_offset)) <<< 1;

	// ----------------------------------------
	// combinational outputs
	// ----------------------------------------
	always_comb
	begin
		mem_we = 1'b0;
		mem_wdata = mem_rdata;
		if (is_add && dest_sel)
		begin
			mem_we = 1'b1;
			mem_wdata = sum;
		end
		else if (is_bset)
		begin
			mem_we = 1'b1;
			mem_wdata = mem_rdata | bit_mask;
		end
		else if (is_fill)
		begin
			mem_we = 1'b1;
			mem_wdata = BYTE_ONES;
		end
	end

	assign push_en = is_call;
	assign top_of_return_stack = ret_addr;
	assign pc_load = is_call;
	assign pc_target = ret_addr + ofs_words;
	assign soft_reset_req = is_rst;

	// ----------------------------------------
	// state: accumulator, flags, idle cycle
	// ----------------------------------------
	logic [DATA_W-1:0] acc_ff;
	logic [DATA_W-1:0] nxt_acc;
	logic [4:0] flags_ff;
	logic [4:0] nxt_flags;
	logic idle_ff;
	logic nxt_idle;

	always_comb
	begin
		nxt_acc = acc_ff;
		nxt_flags = flags_ff;
		nxt_idle = 1'b0;
		if (is_rst)
		begin
			nxt_acc = ACC_RESET;
			nxt_flags = FLAGS_RESET;
		end
		else if (is_add)
		begin
			nxt_flags = add_flags;
			if (!dest_sel)
				nxt_acc = sum;
		end
		if (is_call)
			nxt_idle = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			acc_ff <= ACC_RESET;
			flags_ff <= FLAGS_RESET;
			idle_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			flags_ff <= nxt_flags;
			idle_ff <= nxt_idle;
		end
	end

	assign acc = acc_ff;
	assign status_flags = flags_ff;
	assign busy = idle_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_call;
		is_call;
	endsequence
	sequence s_idle;
		busy && !pc_load && !mem_we && !push_en;
	endsequence

	property p_call_idle;
		@(posedge clk) disable iff (!rstn) s_call |=> s_idle ##1 !busy;
	endproperty
	a_call_idle: assert property (p_call_idle) else $error("call idle cycle wrong");

	property p_push;
		@(posedge clk) disable iff (!rstn)
			push_en |-> pc_load && top_of_return_stack == pc_in + PC_STEP;
	endproperty
	a_push: assert property (p_push) else $error("return address wrong");

	property p_target;
		@(posedge clk) disable iff (!rstn)
			pc_load |-> pc_target == pc_in + PC_STEP + (PC_W'(signed'(call_offset)) <<< 1);
	endproperty
	a_target: assert property (p_target) else $error("call target wrong");

	property p_call_flags;
		@(posedge clk) disable iff (!rstn) is_call |=> $stable(status_flags) && $stable(acc);
	endproperty
	a_call_flags: assert property (p_call_flags) else $error("call changed flags");

	property p_reset;
		@(posedge clk) disable iff (!rstn)
			soft_reset_req |=> acc == ACC_RESET && status_flags == FLAGS_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("soft reset state wrong");

	property p_add_acc;
		@(posedge clk) disable iff (!rstn)
			is_add && !dest_sel |-> !mem_we ##1 acc == $past(acc) + $past(mem_rdata);
	endproperty
	a_add_acc: assert property (p_add_acc) else $error("add to accumulator wrong");

	property p_add_mem;
		@(posedge clk) disable iff (!rstn)
			is_add && dest_sel |-> mem_we && mem_wdata == DATA_W'(acc + mem_rdata) ##1 $stable(acc);
	endproperty
	a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

	property p_bset;
		@(posedge clk) disable iff (!rstn)
			is_bset |-> mem_we && mem_wdata[bit_sel] && ((mem_wdata & ~bit_mask) == (mem_rdata & ~bit_mask))
			##1 $stable(status_flags);
	endproperty
	a_bset: assert property (p_bset) else $error("bit set wrong");

	property p_fill;
		@(posedge clk) disable iff (!rstn)
			is_fill |-> mem_we && mem_wdata == BYTE_ONES && !busy ##1 !busy && $stable(status_flags);
	endproperty
	a_fill: assert property (p_fill) else $error("fill wrong");

	property p_single;
		@(posedge clk) disable iff (!rstn) (is_add || is_bset || is_rst) |=> !busy;
	endproperty
	a_single: assert property (p_single) else $error("single cycle op stalled");
endmodule // idx_ops_unit
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the call, software reset and indexed operation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module tb_top
	import idx_ops_pkg::*;
;
	typedef struct {op_e op; logic [11:0] ptr; logic [6:0] lit; logic d; logic [2:0] b;
		logic [7:0] rd;} row_s;
	logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, dest_sel = 1'b0;
	op_e op = OP_NONE;
	logic [PC_W-1:0] pc_in = '0;
	logic signed [OFS_W-1:0] call_offset = '0;
	logic [LIT_W-1:0] literal = '0;
	logic [2:0] bit_sel = '0;
	logic [ADDR_W-1:0] second_indirect_pointer = '0;
	logic [DATA_W-1:0] mem_rdata = '0, mem_wdata, acc, acc_m;
	logic [ADDR_W-1:0] mem_addr;
	logic mem_we, push_en, pc_load, busy, soft_reset_req;
	logic [PC_W-1:0] top_of_return_stack, pc_target;
	logic [4:0] status_flags, flg_m;
	int n_mismatch = 0, samples_checked = 0;
	row_s rows[8];
	idx_ops_unit u_dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op(op), .pc_in(pc_in),
		.call_offset(call_offset), .literal(literal), .dest_sel(dest_sel), .bit_sel(bit_sel),
		.second_indirect_pointer(second_indirect_pointer), .mem_rdata(mem_rdata),
		.mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .push_en(push_en),
		.top_of_return_stack(top_of_return_stack), .pc_load(pc_load), .pc_target(pc_target),
		.busy(busy), .soft_reset_req(soft_reset_req), .acc(acc), .status_flags(status_flags));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic issue(input row_s r);
		@(posedge clk);
		op_valid <= 1'b1; op <= r.op; second_indirect_pointer <= r.ptr; literal <= r.lit;
		dest_sel <= r.d; bit_sel <= r.b; mem_rdata <= r.rd;
		@(negedge clk);
	endtask
	task automatic idle;
		@(posedge clk);
		op_valid <= 1'b0;
		@(negedge clk);
	endtask
	task automatic run_row(input row_s r);
		logic [8:0] s;
		logic [7:0] wd;
		logic we;
		issue(r);
		s = {1'b0, acc_m} + {1'b0, r.rd};
		we = (r.op != OP_INDEXED_ADD_ACCUMULATOR) || r.d;
		wd = (r.op == OP_INDEXED_ADD_ACCUMULATOR) ? s[7:0] :
			(r.op == OP_INDEXED_BIT_SET) ? (r.rd | (8'h01 << r.b)) : BYTE_ONES;
		`CHK(mem_addr, r.ptr + 12'(r.lit))
		`CHK(mem_we, we)
		if (we) `CHK(mem_wdata, wd)
		if (r.op == OP_INDEXED_FILL_ONES) `CHK(mem_wdata, BYTE_ONES)
		`CHK({push_en, pc_load, soft_reset_req}, 3'h0)
		if (r.op == OP_INDEXED_ADD_ACCUMULATOR)
		begin
			flg_m[FLG_C] = s[8];
			flg_m[FLG_DC] = ({1'b0, acc_m[3:0]} + {1'b0, r.rd[3:0]}) > 5'h0f;
			flg_m[FLG_Z] = (s[7:0] == 8'h00);
			flg_m[FLG_OV] = (acc_m[7] == r.rd[7]) && (s[7] != acc_m[7]);
			flg_m[FLG_N] = s[7];
			if (!r.d) acc_m = s[7:0];
		end
		idle;
		`CHK(acc, acc_m)
		`CHK(status_flags, flg_m)
		`CHK(busy, 1'b0)
	endtask
	// call at c0, a request refused while busy at c1
	task automatic call_chk(input logic [PC_W-1:0] pc, input logic signed [OFS_W-1:0] n);
		@(posedge clk);
		op_valid <= 1'b1; op <= OP_RELATIVE_CALL; pc_in <= pc; call_offset <= n;
		@(negedge clk);
		`CHK(push_en, 1'b1)
		`CHK(top_of_return_stack, pc + PC_STEP)
		`CHK(pc_load, 1'b1)
		`CHK(pc_target, pc + PC_STEP + (PC_W'(n) << 1))
		issue('{OP_INDEXED_FILL_ONES, 12'h0100, 7'h00, 1'b0, 3'h0, 8'h00});
		`CHK({busy, mem_we, push_en, pc_load}, 4'h8)
		`CHK(status_flags, flg_m)
		idle;
		`CHK(busy, 1'b0)
	endtask
	initial
	begin
		#(25 * 4000);
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		rows = '{'{OP_INDEXED_ADD_ACCUMULATOR, 12'h0a00, 7'h2c, 1'b0, 3'h0, 8'h17},
			'{OP_INDEXED_ADD_ACCUMULATOR, 12'h0a00, 7'h2c, 1'b0, 3'h0, 8'h20},
			'{OP_INDEXED_ADD_ACCUMULATOR, 12'h0a00, 7'h5f, 1'b1, 3'h0, 8'hc9},
			'{OP_INDEXED_ADD_ACCUMULATOR, 12'h0f80, 7'h01, 1'b0, 3'h0, 8'h7f},
			'{OP_INDEXED_BIT_SET, 12'h0a00, 7'h0a, 1'b0, 3'h7, 8'h55},
			'{OP_INDEXED_BIT_SET, 12'h0a00, 7'h00, 1'b0, 3'h0, 8'h54},
			'{OP_INDEXED_FILL_ONES, 12'h0f80, 7'h5f, 1'b0, 3'h0, 8'h12},
			'{OP_INDEXED_FILL_ONES, 12'h0000, 7'h00, 1'b0, 3'h0, 8'h00}};
		acc_m = ACC_RESET;
		flg_m = FLAGS_RESET;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		`CHK({acc, status_flags, busy}, {ACC_RESET, FLAGS_RESET, 1'b0})
		foreach (rows[i]) run_row(rows[i]);
		for (int b = 0; b < 8; b++)
			run_row('{OP_INDEXED_BIT_SET, 12'h0300, 7'h10, 1'b0, 3'(b), 8'h00});
		call_chk(21'h01_0000, OFS_MIN);
		call_chk(21'h00_0100, OFS_MAX);
		// out of range offset must leave memory alone
		issue('{OP_INDEXED_FILL_ONES, 12'h0a00, 7'h60, 1'b0, 3'h0, 8'h00});
		`CHK(mem_we, 1'b0)
		idle;
		issue('{OP_SOFT_RESET, 12'h0000, 7'h00, 1'b0, 3'h0, 8'h00});
		`CHK(soft_reset_req, 1'b1)
		idle;
		`CHK({acc, status_flags}, {ACC_RESET, FLAGS_RESET})
		// external reset in mid-run must give the same state as the software reset
		acc_m = ACC_RESET;
		run_row('{OP_INDEXED_ADD_ACCUMULATOR, 12'h0a00, 7'h2c, 1'b0, 3'h0, 8'h81});
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		`CHK({acc, status_flags, busy}, {ACC_RESET, FLAGS_RESET, 1'b0})
		acc_m = ACC_RESET;
		flg_m = FLAGS_RESET;
		run_row('{OP_INDEXED_ADD_ACCUMULATOR, 12'h0a00, 7'h2c, 1'b0, 3'h0, 8'h80});
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
